// ---- logic/i2c_event_control_status.sv ----
// How it works
// - slave address match sets event and address-matched; first-status read clears both.
// - received byte sets byte-finished after ack clock; cleared by status then data read.
// - sent byte sets byte-finished after ack clock; cleared by status read, data write.
// - slave nack: status read clears failure; stop toggle or FFh write clears byte-finished.
// - stop ending slave transfer sets event and stop-detected; second-status read clears.
// - master start sets event and start-sent; status read then address write clears.
// - master address done raises held event; status read then control write clears it.
// - ten-bit header sent sets flags; status read then second address write clears.
// - wait mode changes nothing; enabled interrupts wake the processor.
// - halt freezes registers, ignores bus, resumes on external wake only.
// - one interrupt request, gated by interrupt enable and global mask.
// - disable resets all bits but stop and busy, releases lines; first enable write sets only enable and stop.
// - general call enable acknowledges 00h, 01h always ignored, cleared on disable.
// - start bit gives repeated start as master, start on free bus otherwise.
// - acknowledge-enable decides whether received address and data bytes are acknowledged.
// - master stop bit sends stop after current byte, never while start-sent pends, then self clears.
// - slave stop bit releases both lines after current byte; software clears it.
// - clock held low while header, start, byte, address or post-address events pend.
// - event flag sets on any event; error events cleared by second-status read.
// - direction flag shows transmitted byte while byte-finished; clears on stop, loss, disable.
// - bus-busy follows start and stop detection even while disabled.
// - master flag sets on start request; clears on stop, arbitration loss, disable.
// - standard bus clock is cpu clock over two times divider plus two.
//
// Decided for this implementation: the APB slave port and the register offsets.
`include "i2c_ecs_defs.svh"
`default_nettype none
module i2c_event_control_status (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             scl_o,
	output logic             scl_oe,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        halt_wake,
	output logic             irq_req,
	output logic             wait_wake
);
	// ==========================================================
	// helpers
	function automatic logic [8:0] high_len(input logic [7:0] c);
		high_len = {2'b00, c[6:0]} + `I2C_DIV_OFS;
	endfunction

	function automatic logic [8:0] low_len(input logic [7:0] c);
		logic [8:0] b;
		b = high_len(c);
		low_len = c[7] ? 9'(b << 1) : b;
	endfunction

	// ==========================================================
	// state
	i2c_ecs_pkg::ctl_t  ctl_q;
	i2c_ecs_pkg::sr1_t  sr1_q;
	i2c_ecs_pkg::sr2_t  sr2_q;
	i2c_ecs_pkg::pm_t   pm_q;
	i2c_ecs_pkg::line_t s1_q;
	i2c_ecs_pkg::line_t s2_q;
	i2c_ecs_pkg::line_t sp_q;
	i2c_ecs_pkg::xfer_t xs_q;
	i2c_ecs_pkg::gen_t  gs_q;
	logic [7:0]  ccr_q;
	logic [7:0]  oar1_q;
	logic [7:0]  oar2_q;
	logic [7:0]  dr_q;
	logic [7:0]  sh_q;
	logic [3:0]  cnt_q;
	logic [8:0]  tmr_q;
	logic        tx_q;
	logic        adr_q;
	logic        madr_q;
	logic        hfirst_q;
	logic        mdir_q;
	logic        nack_q;
	logic        match_q;
	logic        sess_q;
	logic        ev6_q;
	logic        arm_q;
	logic        supp_q;
	logic        scl_oe_q;
	logic        sda_oe_q;
	logic        wk1_q;
	logic        wk2_q;
	logic        irq_q;
	logic        wwake_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;

	// ==========================================================
	// decode
	wire        acc      = psel & penable & pready_q;
	wire [3:0]  idx      = paddr[5:2];
	wire        mapped   = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'b00)
				&& (idx <= `I2C_IDX_PM);
	wire        wr       = acc & pwrite & mapped;
	wire        rd       = acc & ~pwrite & mapped;
	wire        wr_ctl   = wr && (idx == `I2C_IDX_CTL);
	wire        wr_dr    = wr && (idx == `I2C_IDX_DR);
	wire        rd_sr1   = rd && (idx == `I2C_IDX_SR1);
	wire        rd_sr2   = rd && (idx == `I2C_IDX_SR2);
	wire        rd_dr    = rd && (idx == `I2C_IDX_DR);
	wire [7:0]  wbyte    = pwdata[7:0];
	wire        stop_off = wr_ctl & ctl_q.stop & ~wbyte[1];
	wire        hold     = sr1_q.hdr | sr1_q.sb | sr1_q.byte_finished | sr1_q.address_matched | ev6_q;
	wire        scl_s    = s2_q.scl;
	wire        sda_s    = s2_q.sda;
	wire        rise     = s2_q.scl & ~sp_q.scl;
	wire        fall     = ~s2_q.scl & sp_q.scl;
	wire        start_det = s2_q.scl & sp_q.scl & sp_q.sda & ~s2_q.sda;
	wire        stop_det  = s2_q.scl & sp_q.scl & ~sp_q.sda & s2_q.sda;
	wire [3:0]  cnt_n    = cnt_q + 4'h1;
	wire        own_hit  = (sh_q[7:1] == oar1_q[7:1]) && (sh_q != `I2C_IGN_ADDR);
	wire        gc_hit   = ctl_q.gc_en && (sh_q == `I2C_GC_ADDR);
	// a stop or repeated start in the first clock after an acknowledge is legal
	wire        mid_byte = (xs_q == i2c_ecs_pkg::x_byte) && (cnt_q != `I2C_CNT_PRE)
				&& (cnt_q != `I2C_CNT_FIRST);
	wire        err_clr  = rd_sr2 & (sr2_q.af | sr2_q.stop_detected | sr2_q.arbitration_lost | sr2_q.bus_error);
	wire        hdr_byte = (wbyte[7:3] == `I2C_HDR_PAT) & ~wbyte[0];

	logic [7:0] rbyte;
	always_comb begin
		unique case (idx)
			`I2C_IDX_CTL:  rbyte = ctl_q & `I2C_CTL_MASK;
			`I2C_IDX_SR1:  rbyte = sr1_q;
			`I2C_IDX_SR2:  rbyte = sr2_q;
			`I2C_IDX_CCR:  rbyte = ccr_q;
			`I2C_IDX_OAR1: rbyte = oar1_q;
			`I2C_IDX_OAR2: rbyte = oar2_q;
			`I2C_IDX_DR:   rbyte = dr_q;
			`I2C_IDX_PM:   rbyte = {5'h00, pm_q};
			default:       rbyte = `I2C_RST_BYTE;
		endcase
	end

	// ==========================================================
	// synchronisers and apb handshake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q  <= '1;
			s2_q  <= '1;
			sp_q  <= '1;
			wk1_q <= 1'b0;
			wk2_q <= 1'b0;
		end else begin
			s1_q  <= '{scl: scl_i, sda: sda_i};
			s2_q  <= s1_q;
			sp_q  <= s2_q;
			wk1_q <= halt_wake;
			wk2_q <= wk1_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~mapped;
			prdata_q  <= (psel & ~pwrite & mapped) ? {24'h000000, rbyte} : 32'h0000_0000;
		end
	end

	// ==========================================================
	// registers, flags and byte engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q    <= i2c_ecs_pkg::ctl_t'(`I2C_RST_BYTE);
			sr1_q    <= i2c_ecs_pkg::sr1_t'(`I2C_RST_BYTE);
			sr2_q    <= i2c_ecs_pkg::sr2_t'(`I2C_RST_BYTE);
			pm_q     <= '0;
			ccr_q    <= `I2C_RST_BYTE;
			oar1_q   <= `I2C_RST_BYTE;
			oar2_q   <= `I2C_RST_OAR2;
			dr_q     <= `I2C_RST_BYTE;
			sh_q     <= `I2C_RST_BYTE;
			cnt_q    <= `I2C_CNT_PRE;
			tmr_q    <= '0;
			xs_q     <= i2c_ecs_pkg::x_idle;
			gs_q     <= i2c_ecs_pkg::g_idle;
			{tx_q, adr_q, madr_q, hfirst_q, mdir_q, nack_q} <= '0;
			{match_q, sess_q, ev6_q, arm_q, supp_q} <= '0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (pm_q.halt) begin
			// frozen: lines released, nothing acknowledged
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			if (wk2_q)
				pm_q.halt <= 1'b0;
		end else begin
			// ---------------- software side: writes and clears
			if (wr && (idx == `I2C_IDX_PM))
				pm_q <= i2c_ecs_pkg::pm_t'(wbyte[2:0]);
			if (wr && (idx == `I2C_IDX_CCR))
				ccr_q <= wbyte;
			if (wr && (idx == `I2C_IDX_OAR1))
				oar1_q <= wbyte;
			if (wr && (idx == `I2C_IDX_OAR2))
				oar2_q <= wbyte & `I2C_OAR2_MASK;
			if (wr_ctl) begin
				if (ctl_q.pe) begin
					ctl_q <= i2c_ecs_pkg::ctl_t'(wbyte & `I2C_CTL_MASK);
					if (wbyte[3])
						sr1_q.msl <= 1'b1;
				end else begin
					ctl_q.pe   <= wbyte[5];
					ctl_q.stop <= wbyte[1];
				end
			end
			if (acc)
				arm_q <= rd_sr1;
			if (rd_sr1) begin
				sr1_q.address_matched <= 1'b0;
				sr2_q.af   <= 1'b0;
				if (sr1_q.address_matched) begin
					sr1_q.event_pending <= 1'b0;
					if (!tx_q) begin
						xs_q  <= i2c_ecs_pkg::x_byte;
						cnt_q <= `I2C_CNT_FIRST;
					end
				end
			end
			if (rd_sr2) begin
				sr2_q.arbitration_lost  <= 1'b0;
				sr2_q.bus_error  <= 1'b0;
				sr2_q.af    <= 1'b0;
				sr2_q.stop_detected <= 1'b0;
				if (err_clr)
					sr1_q.event_pending <= 1'b0;
			end
			if (rd_dr && arm_q && sr1_q.byte_finished && !sr1_q.direction_flag) begin
				sr1_q.byte_finished <= 1'b0;
				sr1_q.event_pending <= 1'b0;
				sr1_q.direction_flag <= 1'b0;
				xs_q      <= i2c_ecs_pkg::x_byte;
				cnt_q     <= `I2C_CNT_FIRST;
			end
			if (wr_ctl && arm_q && ev6_q) begin
				ev6_q     <= 1'b0;
				sr1_q.event_pending <= 1'b0;
				if (!mdir_q) begin
					xs_q  <= i2c_ecs_pkg::x_byte;
					cnt_q <= `I2C_CNT_FIRST;
					tx_q  <= 1'b0;
				end
			end
			if (stop_off && sr1_q.byte_finished && !sr1_q.msl) begin
				sr1_q.byte_finished <= 1'b0;
				sr1_q.event_pending <= 1'b0;
				sr1_q.direction_flag <= 1'b0;
				supp_q    <= 1'b1;
				xs_q      <= i2c_ecs_pkg::x_idle;
				sda_oe_q  <= 1'b0;
			end
			if (wr_dr) begin
				dr_q <= wbyte;
				if (sr2_q.af && sr1_q.byte_finished && (wbyte == `I2C_REL_BYTE)) begin
					sr1_q.byte_finished <= 1'b0;
					sr1_q.event_pending <= 1'b0;
					sr1_q.direction_flag <= 1'b0;
					xs_q      <= i2c_ecs_pkg::x_idle;
				end else if (xs_q == i2c_ecs_pkg::x_wait && (tx_q || sr1_q.sb || sr1_q.hdr)
						&& (arm_q || !hold)) begin
					sh_q     <= wbyte;
					cnt_q    <= `I2C_CNT_FIRST;
					xs_q     <= i2c_ecs_pkg::x_byte;
					sda_oe_q <= ~wbyte[7];
					if (sr1_q.sb) begin
						sr1_q.sb  <= 1'b0;
						madr_q    <= 1'b1;
						hfirst_q  <= hdr_byte;
						mdir_q    <= wbyte[0];
						tx_q      <= 1'b1;
					end else if (sr1_q.hdr) begin
						sr1_q.hdr <= 1'b0;
						madr_q    <= 1'b1;
						hfirst_q  <= 1'b0;
						tx_q      <= 1'b1;
					end
					sr1_q.byte_finished <= 1'b0;
					sr1_q.direction_flag <= 1'b0;
					sr1_q.event_pending <= 1'b0;
				end
			end

			// ---------------- master clock and condition generator
			unique case (gs_q)
				i2c_ecs_pkg::g_idle: begin
					if (ctl_q.pe && ctl_q.start && sr1_q.msl && !sr1_q.busy
							&& scl_s && sda_s) begin
						sda_oe_q <= 1'b1;
						tmr_q    <= high_len(ccr_q);
						gs_q     <= i2c_ecs_pkg::g_start;
					end
				end
				i2c_ecs_pkg::g_start: begin
					if (tmr_q != '0) begin
						tmr_q <= tmr_q - `I2C_TMR_ONE;
					end else begin
						scl_oe_q    <= 1'b1;
						ctl_q.start <= 1'b0;
						sr1_q.sb    <= 1'b1;
						sr1_q.event_pending   <= 1'b1;
						xs_q        <= i2c_ecs_pkg::x_wait;
						tmr_q       <= low_len(ccr_q);
						gs_q        <= i2c_ecs_pkg::g_low;
					end
				end
				i2c_ecs_pkg::g_low: begin
					if (!scl_s && tmr_q != '0) begin
						tmr_q <= tmr_q - `I2C_TMR_ONE;
					end else if (!scl_s) begin
						if (xs_q == i2c_ecs_pkg::x_byte) begin
							scl_oe_q <= 1'b0;
							tmr_q    <= high_len(ccr_q);
							gs_q     <= i2c_ecs_pkg::g_high;
						end else if (ctl_q.stop && !sr1_q.sb) begin
							sda_oe_q <= 1'b1;
							scl_oe_q <= 1'b0;
							tmr_q    <= high_len(ccr_q);
							gs_q     <= i2c_ecs_pkg::g_stop;
						end else if (ctl_q.start) begin
							sda_oe_q <= 1'b0;
							scl_oe_q <= 1'b0;
							tmr_q    <= high_len(ccr_q);
							gs_q     <= i2c_ecs_pkg::g_rep;
						end
					end
				end
				i2c_ecs_pkg::g_high: begin
					if (scl_s && tmr_q != '0) begin
						tmr_q <= tmr_q - `I2C_TMR_ONE;
					end else if (scl_s) begin
						scl_oe_q <= 1'b1;
						tmr_q    <= low_len(ccr_q);
						gs_q     <= i2c_ecs_pkg::g_low;
					end
				end
				i2c_ecs_pkg::g_rep: begin
					if (scl_s && tmr_q != '0) begin
						tmr_q <= tmr_q - `I2C_TMR_ONE;
					end else if (scl_s) begin
						sda_oe_q <= 1'b1;
						tmr_q    <= high_len(ccr_q);
						gs_q     <= i2c_ecs_pkg::g_start;
					end
				end
				i2c_ecs_pkg::g_stop: begin
					if (scl_s && tmr_q != '0) begin
						tmr_q <= tmr_q - `I2C_TMR_ONE;
					end else if (scl_s) begin
						sda_oe_q   <= 1'b0;
						ctl_q.stop <= 1'b0;
						xs_q       <= i2c_ecs_pkg::x_idle;
						gs_q       <= i2c_ecs_pkg::g_idle;
					end
				end
			endcase

			// slave side holds the clock low while an event waits
			if (!sr1_q.msl)
				scl_oe_q <= ctl_q.pe && (xs_q == i2c_ecs_pkg::x_wait) && hold && !scl_s;

			// ---------------- bit engine on observed clock edges
			if (ctl_q.pe && xs_q == i2c_ecs_pkg::x_byte && rise) begin
				if (cnt_q < `I2C_CNT_ACK && !tx_q)
					sh_q <= {sh_q[6:0], sda_s};
				if (cnt_q == `I2C_CNT_ACK && tx_q)
					nack_q <= sda_s;
				if (cnt_q < `I2C_CNT_ACK && tx_q && sr1_q.msl && !sda_oe_q && !sda_s) begin
					sr2_q.arbitration_lost <= 1'b1;
					sr1_q.event_pending  <= 1'b1;
					sr1_q.msl  <= 1'b0;
					sr1_q.direction_flag  <= 1'b0;
					xs_q       <= i2c_ecs_pkg::x_idle;
					gs_q       <= i2c_ecs_pkg::g_idle;
					scl_oe_q   <= 1'b0;
				end
			end
			if (ctl_q.pe && xs_q == i2c_ecs_pkg::x_byte && fall) begin
				if (cnt_q == `I2C_CNT_PRE) begin
					cnt_q <= `I2C_CNT_FIRST;
				end else if (cnt_q != `I2C_CNT_ACK) begin
					cnt_q <= cnt_n;
					if (tx_q && cnt_n < `I2C_CNT_ACK) begin
						sh_q     <= {sh_q[6:0], 1'b1};
						sda_oe_q <= ~sh_q[6];
					end else if (tx_q) begin
						sda_oe_q <= 1'b0;
					end else if (cnt_n == `I2C_CNT_ACK) begin
						match_q  <= own_hit | gc_hit;
						sda_oe_q <= ctl_q.ack_en && (!adr_q || own_hit || gc_hit);
					end
				end else begin
					sda_oe_q <= 1'b0;
					adr_q    <= 1'b0;
					madr_q   <= 1'b0;
					xs_q     <= i2c_ecs_pkg::x_wait;
					if (adr_q) begin
						if (match_q) begin
							sr1_q.address_matched <= 1'b1;
							sr1_q.event_pending  <= 1'b1;
							sr2_q.gcal <= (sh_q == `I2C_GC_ADDR);
							tx_q       <= sh_q[0];
							sess_q     <= 1'b1;
						end else begin
							xs_q <= i2c_ecs_pkg::x_idle;
						end
					end else if (madr_q && nack_q) begin
						sr2_q.af  <= 1'b1;
						sr1_q.event_pending <= 1'b1;
					end else if (madr_q && hfirst_q) begin
						sr1_q.hdr <= 1'b1;
						sr1_q.event_pending <= 1'b1;
					end else if (madr_q) begin
						ev6_q     <= 1'b1;
						sr1_q.event_pending <= 1'b1;
						tx_q      <= ~mdir_q;
					end else if (!sr1_q.msl && ctl_q.stop) begin
						xs_q <= i2c_ecs_pkg::x_idle;
					end else if (tx_q && nack_q) begin
						sr2_q.af  <= 1'b1;
						sr1_q.event_pending <= 1'b1;
						sr1_q.byte_finished <= !sr1_q.msl;
						sr1_q.direction_flag <= !sr1_q.msl;
					end else begin
						sr1_q.byte_finished <= 1'b1;
						sr1_q.event_pending <= 1'b1;
						sr1_q.direction_flag <= tx_q;
						if (!tx_q)
							dr_q <= sh_q;
					end
				end
			end

			// ---------------- start and stop seen on the bus
			if (start_det) begin
				sr1_q.busy <= 1'b1;
				if (ctl_q.pe && mid_byte && !madr_q) begin
					sr2_q.bus_error <= 1'b1;
					sr1_q.event_pending  <= 1'b1;
				end
				if (ctl_q.pe && !sr1_q.msl) begin
					xs_q     <= i2c_ecs_pkg::x_byte;
					cnt_q    <= `I2C_CNT_PRE;
					adr_q    <= 1'b1;
					tx_q     <= 1'b0;
					sess_q   <= 1'b0;
					sda_oe_q <= 1'b0;
				end else if (ctl_q.pe) begin
					cnt_q <= `I2C_CNT_PRE;
				end
			end
			if (stop_det) begin
				sr1_q.busy <= 1'b0;
				sr1_q.msl  <= 1'b0;
				sr1_q.direction_flag  <= 1'b0;
				sr2_q.gcal <= 1'b0;
				supp_q     <= 1'b0;
				if (ctl_q.pe && mid_byte) begin
					sr2_q.bus_error <= 1'b1;
					sr1_q.event_pending  <= 1'b1;
				end
				if (ctl_q.pe && sess_q && !sr1_q.msl && !supp_q) begin
					sr2_q.stop_detected <= 1'b1;
					sr1_q.event_pending   <= 1'b1;
				end
				if (ctl_q.pe && !sr1_q.msl) begin
					xs_q     <= i2c_ecs_pkg::x_idle;
					sess_q   <= 1'b0;
					sda_oe_q <= 1'b0;
				end
			end

			// ---------------- disabled: clear all but stop, enable and busy
			if (!ctl_q.pe) begin
				ctl_q.gc_en <= 1'b0;
				ctl_q.start <= 1'b0;
				ctl_q.ack_en <= 1'b0;
				ctl_q.interrupt_enable_bit   <= 1'b0;
				{sr1_q.event_pending, sr1_q.hdr, sr1_q.direction_flag, sr1_q.byte_finished} <= '0;
				{sr1_q.address_matched, sr1_q.msl, sr1_q.sb} <= '0;
				sr2_q    <= i2c_ecs_pkg::sr2_t'(`I2C_RST_BYTE);
				{ev6_q, arm_q, supp_q, sess_q, adr_q, madr_q} <= '0;
				xs_q     <= i2c_ecs_pkg::x_idle;
				gs_q     <= i2c_ecs_pkg::g_idle;
				scl_oe_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// interrupt request and wake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q   <= 1'b0;
			wwake_q <= 1'b0;
		end else begin
			irq_q   <= ctl_q.interrupt_enable_bit & sr1_q.event_pending & ~pm_q.gmask & ~pm_q.halt;
			wwake_q <= ctl_q.interrupt_enable_bit & sr1_q.event_pending & ~pm_q.gmask & pm_q.wait_m;
		end
	end

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;
	assign scl_oe    = scl_oe_q;
	assign sda_oe    = sda_oe_q;
	assign irq_req   = irq_q;
	assign wait_wake = wwake_q;
endmodule
`default_nettype wire

// ---- logic/i2c_ecs_defs.svh ----
`ifndef I2C_ECS_DEFS_SVH
`define I2C_ECS_DEFS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define I2C_IDX_CTL   4'h0
`define I2C_IDX_SR1   4'h1
`define I2C_IDX_SR2   4'h2
`define I2C_IDX_CCR   4'h3
`define I2C_IDX_OAR1  4'h4
`define I2C_IDX_OAR2  4'h5
`define I2C_IDX_DR    4'h6
`define I2C_IDX_PM    4'h7

// ==========================================================
// reset values and masks
`define I2C_RST_BYTE  8'h00
`define I2C_RST_OAR2  8'h40
`define I2C_OAR2_MASK 8'hC6
`define I2C_CTL_MASK  8'h3F

// ==========================================================
// bus constants
`define I2C_GC_ADDR   8'h00
`define I2C_IGN_ADDR  8'h01
`define I2C_REL_BYTE  8'hFF
`define I2C_HDR_PAT   5'h1E
`define I2C_CNT_PRE   4'hF
`define I2C_CNT_FIRST 4'h0
`define I2C_CNT_ACK   4'h8
`define I2C_DIV_OFS   9'h002
`define I2C_TMR_ONE   9'h001

`endif

// ---- logic/i2c_ecs_pkg.sv ----
`default_nettype none
package i2c_ecs_pkg;
	typedef struct packed {
		logic [1:0] rsv;
		logic       pe;
		logic       gc_en;
		logic       start;
		logic       ack_en;
		logic       stop;
		logic       interrupt_enable_bit;
	} ctl_t;
	typedef struct packed {
		logic event_pending;
		logic hdr;
		logic direction_flag;
		logic busy;
		logic byte_finished;
		logic address_matched;
		logic msl;
		logic sb;
	} sr1_t;
	typedef struct packed {
		logic [2:0] rsv;
		logic       af;
		logic       stop_detected;
		logic       arbitration_lost;
		logic       bus_error;
		logic       gcal;
	} sr2_t;
	typedef struct packed {
		logic gmask;
		logic halt;
		logic wait_m;
	} pm_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} line_t;
	typedef enum logic [2:0] {
		x_idle = 3'b001,
		x_byte = 3'b010,
		x_wait = 3'b100
	} xfer_t;
	typedef enum logic [5:0] {
		g_idle  = 6'b000001,
		g_start = 6'b000010,
		g_low   = 6'b000100,
		g_high  = 6'b001000,
		g_stop  = 6'b010000,
		g_rep   = 6'b100000
	} gen_t;
endpackage
`default_nettype wire

// ---- verif/i2c_ecs_properties.sv ----
`default_nettype none
module i2c_ecs_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        scl_o,
	input wire logic        scl_oe,
	input wire logic        sda_o,
	input wire logic        sda_oe,
	input wire logic        irq_req,
	input wire logic        wait_wake
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==========================================================
	// register access handshake
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready stayed high");
	chk_ready_answer: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	chk_ready_qualified: assert property (pready |-> psel && penable)
		else $error("pready without access");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr outside answer");
	chk_err_reads_zero: assert property (pready && pslverr |-> prdata == 32'h00000000)
		else $error("refused read not zero");
	chk_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	// ==========================================================
	// line and request outputs
	chk_lines_drain: assert property (!scl_o && !sda_o)
		else $error("line data not low");
	chk_release_idle: assert property ($rose(presetn) |-> !scl_oe && !sda_oe && !irq_req && !wait_wake)
		else $error("outputs active after reset");
endmodule
bind i2c_event_control_status i2c_ecs_checker chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o),
	.sda_oe(sda_oe), .irq_req(irq_req), .wait_wake(wait_wake)
);
`default_nettype wire

// ---- verif/i2c_far_master.sv ----
`default_nettype none
module i2c_far_master (
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	output var  logic scl_oe,
	output var  logic sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic hp;
		repeat (40) @(posedge clk);
	endtask
	// waits out clock stretching by the device
	task automatic rel_scl;
		scl_oe <= 1'b0;
		do @(posedge clk); while (scl !== 1'b1);
	endtask
	task automatic start;
		sda_oe <= 1'b1;
		hp();
		scl_oe <= 1'b1;
		hp();
	endtask
	// msb first, then samples the acknowledge bit
	task automatic tx(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			repeat (8) @(posedge clk);
			sda_oe <= ~b[i];
			hp();
			rel_scl();
			hp();
			scl_oe <= 1'b1;
		end
		repeat (8) @(posedge clk);
		sda_oe <= 1'b0;
		hp();
		rel_scl();
		ack = sda;
		hp();
		scl_oe <= 1'b1;
	endtask
	task automatic stop;
		repeat (8) @(posedge clk);
		sda_oe <= 1'b1;
		hp();
		rel_scl();
		hp();
		sda_oe <= 1'b0;
		hp();
	endtask
endmodule
`default_nettype wire

// ---- verif/test_i2c_event_control_status.sv ----
`include "i2c_ecs_defs.svh"
`default_nettype none
module test_i2c_event_control_status;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, halt_wake, se, ack;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq_req, wait_wake;
	logic        m_scl_oe, m_sda_oe;
	logic [7:0]  r, d, v;
	logic [7:0]  adr [4] = '{8'h84, 8'h52, 8'h01, 8'h00};
	logic        nak [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	int          fail_count, comparisons, seed, i;
	wire         scl_w = ~(scl_oe | m_scl_oe);
	wire         sda_w = ~(sda_oe | m_sda_oe);
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	i2c_event_control_status dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .halt_wake(halt_wake),
		.irq_req(irq_req), .wait_wake(wait_wake));
	i2c_far_master far (.clk(pclk), .scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe),
		.sda_oe(m_sda_oe));
	// ==========================================================
	// helpers
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [3:0] ix, input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {6'h00, ix, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata[7:0];
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ix, input string n, input logic [7:0] e);
		apb(1'b0, ix, 8'h00);
		chk(n, r, e);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		wt(60000);
		fail_count++;
		wrap_up();
	end
	// ==========================================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, halt_wake} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		seed = 32'h903A;
		wt(5);
		presetn <= 1'b1;
		rd(`I2C_IDX_CTL, "ctl_reset", 8'h00);
		rd(`I2C_IDX_SR1, "sr1_reset", 8'h00);
		rd(`I2C_IDX_SR2, "sr2_reset", 8'h00);
		apb(1'b0, 4'h8, 8'h00);
		chk("unmapped_err", {7'h00, se}, 8'h01);
		v = $random(seed);
		v[5] = 1'b1;
		v[1] = 1'b0;
		apb(1'b1, `I2C_IDX_CTL, v);
		rd(`I2C_IDX_CTL, "ctl_first", 8'h20);
		apb(1'b1, `I2C_IDX_CTL, 8'h35);
		rd(`I2C_IDX_CTL, "ctl_second", 8'h35);
		apb(1'b1, `I2C_IDX_OAR1, 8'h84);
		apb(1'b1, `I2C_IDX_PM, 8'h00);
		for (int k = 0; k < 4; k++) begin
			far.start();
			far.tx(adr[k], ack);
			chk("addr_ack", {7'h00, ack}, {7'h00, nak[k]});
			wt(30);
			if (!nak[k]) begin
				chk("scl_hold", {7'h00, scl_oe}, 8'h01);
				chk("irq", {7'h00, irq_req}, 8'h01);
				if (k == 0) begin
					apb(1'b1, `I2C_IDX_PM, 8'h04);
					wt(3);
					chk("irq_masked", {7'h00, irq_req}, 8'h00);
					apb(1'b1, `I2C_IDX_PM, 8'h01);
					wt(3);
					chk("wait_wake", {7'h00, wait_wake}, 8'h01);
					apb(1'b1, `I2C_IDX_PM, 8'h02);
					wt(3);
					chk("irq_halt", {6'h00, irq_req, scl_oe}, 8'h00);
					apb(1'b1, `I2C_IDX_PM, 8'h00);
					rd(`I2C_IDX_PM, "pm_frozen", 8'h02);
					halt_wake <= 1'b1;
					wt(4);
					halt_wake <= 1'b0;
					rd(`I2C_IDX_PM, "pm_resume", 8'h00);
					chk("irq_resume", {7'h00, irq_req}, 8'h01);
				end
				rd(`I2C_IDX_SR1, "sr1_match", 8'h94);
				rd(`I2C_IDX_SR1, "sr1_cleared", 8'h10);
				if (k == 0) begin
					d = $random(seed);
					far.tx(d, ack);
					chk("data_ack", {7'h00, ack}, 8'h00);
					wt(30);
					rd(`I2C_IDX_SR1, "sr1_byte", 8'h98);
					rd(`I2C_IDX_DR, "rx_byte", d);
					rd(`I2C_IDX_SR1, "sr1_byte_done", 8'h10);
				end
			end
			far.stop();
			wt(30);
			rd(`I2C_IDX_SR1, "sr1_stop", nak[k] ? 8'h00 : 8'h80);
			rd(`I2C_IDX_SR2, "sr2_stop", nak[k] ? 8'h00 : 8'h08);
			rd(`I2C_IDX_SR1, "sr1_idle", 8'h00);
		end
		apb(1'b1, `I2C_IDX_CTL, 8'h2D);
		for (i = 0; i < 2000 && scl_oe !== 1'b1; i++) @(posedge pclk);
		wt(40);
		rd(`I2C_IDX_SR1, "sr1_start", 8'h93);
		chk("scl_start", {7'h00, scl_oe}, 8'h01);
		rd(`I2C_IDX_CTL, "ctl_start", 8'h25);
		apb(1'b1, `I2C_IDX_CTL, 8'h00);
		wt(8);
		chk("lines_off", {6'h00, scl_oe, sda_oe}, 8'h00);
		apb(1'b0, `I2C_IDX_SR1, 8'h00);
		chk("sr1_off", r & 8'hEF, 8'h00);
		rd(`I2C_IDX_CTL, "ctl_off", 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
